/* design/rps_pkg.sv */
`default_nettype none
package rps_pkg;

  localparam int SEL_W  = 5;
  localparam int REG_W  = 16;
  localparam int ADDR_W = 4;

  // Register offsets.
  localparam logic [3:0] OFS_IN_ROUTE  = 4'h0;
  localparam logic [3:0] OFS_OUT_ROUTE = 4'h1;
  localparam logic [3:0] OFS_LOCK      = 4'h2;

  // Field positions.
  localparam int IN_SEL_LSB   = 0;
  localparam int PIN0_SEL_LSB = 0;
  localparam int PIN1_SEL_LSB = 8;
  localparam int LOCK_BIT     = 0;

  // Reset values and the null output code.
  localparam logic [4:0] IN_SEL_RST  = 5'h1f;
  localparam logic [4:0] OUT_SEL_RST = 5'h00;
  localparam logic [4:0] OUT_NULL    = 5'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } rps_bus_req_t;

endpackage : rps_pkg
`default_nettype wire

/* design/rps_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_top #(
  parameter int NUM_PINS  = 26,
  parameter int NUM_FUNCS = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire rps_pkg::rps_bus_req_t    bus_req,
  output var  logic [rps_pkg::REG_W-1:0] rd_data,
  input  wire logic [NUM_PINS-1:0]      remappable_pin_in,
  input  wire logic [NUM_FUNCS-1:0]     periph_out,
  output var  logic                     spi_slave_select_input,
  output var  logic                     remappable_pin_zero,
  output var  logic                     remappable_pin_one,
  output var  logic                     remappable_pin_zero_oe,
  output var  logic                     remappable_pin_one_oe,
  output var  logic                     pin_config_lock
);

  logic [rps_pkg::SEL_W-1:0] slave_select_input_pin_sel;
  logic [rps_pkg::SEL_W-1:0] pin0_output_function_sel;
  logic [rps_pkg::SEL_W-1:0] pin1_output_function_sel;
  logic [NUM_PINS-1:0]       pin_meta;
  logic [NUM_PINS-1:0]       pin_sync;

  // Codes past the last real source fall back to a fixed level, so an unused code never floats.
  function automatic logic pick(input logic [NUM_FUNCS-1:0]     v,
                                input logic [rps_pkg::SEL_W-1:0] s,
                                input int                        lim,
                                input logic                      dflt);
    pick = (int'(s) < lim) ? v[s] : dflt;
  endfunction : pick

  // Bits that a register really holds; every other position must read back as zero.
  function automatic logic [rps_pkg::REG_W-1:0] live_bits(input logic [rps_pkg::ADDR_W-1:0] a);
    logic [rps_pkg::REG_W-1:0] ones;
    ones = rps_pkg::REG_W'({rps_pkg::SEL_W{1'b1}});
    case (a)
      rps_pkg::OFS_IN_ROUTE:  live_bits = ones << rps_pkg::IN_SEL_LSB;
      rps_pkg::OFS_OUT_ROUTE: live_bits =
        (ones << rps_pkg::PIN1_SEL_LSB) | (ones << rps_pkg::PIN0_SEL_LSB);
      rps_pkg::OFS_LOCK:      live_bits = rps_pkg::REG_W'(1'b1) << rps_pkg::LOCK_BIT;
      default:                live_bits = '0;
    endcase
  endfunction : live_bits

  wire logic sel_wr_ok  = bus_req.wr && !pin_config_lock;
  wire logic wr_in      = sel_wr_ok && bus_req.addr == rps_pkg::OFS_IN_ROUTE;
  wire logic wr_out     = sel_wr_ok && bus_req.addr == rps_pkg::OFS_OUT_ROUTE;
  wire logic wr_lock    = bus_req.wr && bus_req.addr == rps_pkg::OFS_LOCK;
  wire logic [NUM_FUNCS-1:0] pins_wide = NUM_FUNCS'(pin_sync);
  wire logic ss_next    =
    pick(pins_wide, slave_select_input_pin_sel, NUM_PINS, 1'b1);
  wire logic [NUM_FUNCS-1:0] fn_vec = {periph_out[NUM_FUNCS-1:1], 1'b0};
  wire logic p0_next    = pick(fn_vec, pin0_output_function_sel, NUM_FUNCS, 1'b0);
  wire logic p1_next    = pick(fn_vec, pin1_output_function_sel, NUM_FUNCS, 1'b0);
  wire logic p0_oe_next = pin0_output_function_sel != rps_pkg::OUT_NULL;
  wire logic p1_oe_next = pin1_output_function_sel != rps_pkg::OUT_NULL;

  // Zero-filled read words keep reserved bits at zero.
  wire logic [rps_pkg::REG_W-1:0] rd_in   = rps_pkg::REG_W'(slave_select_input_pin_sel);
  wire logic [rps_pkg::REG_W-1:0] rd_out  =
    (rps_pkg::REG_W'(pin1_output_function_sel) << rps_pkg::PIN1_SEL_LSB) |
    (rps_pkg::REG_W'(pin0_output_function_sel) << rps_pkg::PIN0_SEL_LSB);
  wire logic [rps_pkg::REG_W-1:0] rd_lock = rps_pkg::REG_W'(pin_config_lock);
  wire logic [rps_pkg::REG_W-1:0] next_rd_data =
    !bus_req.rd                                 ? '0 :
    bus_req.addr == rps_pkg::OFS_IN_ROUTE       ? rd_in :
    bus_req.addr == rps_pkg::OFS_OUT_ROUTE      ? rd_out :
    bus_req.addr == rps_pkg::OFS_LOCK           ? rd_lock : '0;

  // Pins come from outside the clock domain, so they pass two stages first.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_meta <= '1;
      pin_sync <= '1;
    end
    else if (clk_en)
    begin
      pin_meta <= remappable_pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      slave_select_input_pin_sel <= rps_pkg::IN_SEL_RST;
      pin0_output_function_sel   <= rps_pkg::OUT_SEL_RST;
      pin1_output_function_sel   <= rps_pkg::OUT_SEL_RST;
      pin_config_lock            <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_in)
        slave_select_input_pin_sel <= bus_req.wdata[rps_pkg::IN_SEL_LSB +: rps_pkg::SEL_W];
      if (wr_out)
      begin
        pin1_output_function_sel <= bus_req.wdata[rps_pkg::PIN1_SEL_LSB +: rps_pkg::SEL_W];
        pin0_output_function_sel <= bus_req.wdata[rps_pkg::PIN0_SEL_LSB +: rps_pkg::SEL_W];
      end
      if (wr_lock)
        pin_config_lock <= bus_req.wdata[rps_pkg::LOCK_BIT];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rd_data                <= '0;
      spi_slave_select_input <= 1'b1;
      remappable_pin_zero    <= 1'b0;
      remappable_pin_one     <= 1'b0;
      remappable_pin_zero_oe <= 1'b0;
      remappable_pin_one_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_data                <= next_rd_data;
      spi_slave_select_input <= ss_next;
      remappable_pin_zero    <= p0_next;
      remappable_pin_one     <= p1_next;
      remappable_pin_zero_oe <= p0_oe_next;
      remappable_pin_one_oe  <= p1_oe_next;
    end
  end

  AST_LOCKED_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pin_config_lock && bus_req.wr |=> $stable(pin0_output_function_sel)
      && $stable(pin1_output_function_sel) && $stable(slave_select_input_pin_sel))
    else $error("Selector changed while locked.");

  AST_UNLOCKED_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !pin_config_lock && bus_req.wr && bus_req.addr == rps_pkg::OFS_OUT_ROUTE
      |=> pin1_output_function_sel
        == $past(bus_req.wdata[rps_pkg::PIN1_SEL_LSB +: rps_pkg::SEL_W])
      && pin0_output_function_sel
        == $past(bus_req.wdata[rps_pkg::PIN0_SEL_LSB +: rps_pkg::SEL_W]))
    else $error("Unlocked output-route write not stored.");

  AST_IN_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !pin_config_lock && bus_req.wr && bus_req.addr == rps_pkg::OFS_IN_ROUTE
      |=> slave_select_input_pin_sel
        == $past(bus_req.wdata[rps_pkg::IN_SEL_LSB +: rps_pkg::SEL_W]))
    else $error("Input-route write not stored.");

  AST_LOCK_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.wr && bus_req.addr == rps_pkg::OFS_LOCK
      |=> pin_config_lock == $past(bus_req.wdata[rps_pkg::LOCK_BIT]))
    else $error("Lock bit write not stored.");

  AST_OUT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !(bus_req.wr && bus_req.addr == rps_pkg::OFS_OUT_ROUTE)
      |=> $stable(pin0_output_function_sel) && $stable(pin1_output_function_sel))
    else $error("Output selectors changed without a write.");

  AST_NULL_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pin0_output_function_sel == rps_pkg::OUT_NULL
      |=> !remappable_pin_zero_oe && !remappable_pin_zero)
    else $error("Null selector drives pin zero.");

  AST_NULL_OFF_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pin1_output_function_sel == rps_pkg::OUT_NULL
      |=> !remappable_pin_one_oe && !remappable_pin_one)
    else $error("Null selector drives pin one.");

  AST_PIN0_FUNC: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pin0_output_function_sel != rps_pkg::OUT_NULL
      |=> remappable_pin_zero_oe
      && remappable_pin_zero == $past(periph_out[pin0_output_function_sel]))
    else $error("Pin zero does not carry its selected function.");

  AST_PIN1_FUNC: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pin1_output_function_sel != rps_pkg::OUT_NULL
      |=> remappable_pin_one_oe
      && remappable_pin_one == $past(periph_out[pin1_output_function_sel]))
    else $error("Pin one does not carry its selected function.");

  AST_NO_PIN_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && int'(slave_select_input_pin_sel) >= NUM_PINS |=> spi_slave_select_input)
    else $error("Code past the last pin does not idle high.");

  AST_PIN_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && slave_select_input_pin_sel == 5'h00 |=> spi_slave_select_input == $past(pin_sync[0]))
    else $error("Code zero does not follow pin zero.");

  AST_PIN_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && slave_select_input_pin_sel == 5'h01 |=> spi_slave_select_input == $past(pin_sync[1]))
    else $error("Code one does not follow pin one.");

  AST_RD_IN_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.rd |=> (rd_data & ~live_bits($past(bus_req.addr))) == '0)
    else $error("Reserved bits read nonzero.");

  AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !bus_req.rd |=> rd_data == '0)
    else $error("Read data not zero outside a read.");

  AST_RD_IN: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == rps_pkg::OFS_IN_ROUTE
      |=> rd_data[rps_pkg::IN_SEL_LSB +: rps_pkg::SEL_W] == $past(slave_select_input_pin_sel))
    else $error("Input-route readback wrong.");

  AST_LOCK_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == rps_pkg::OFS_LOCK
      |=> rd_data == rps_pkg::REG_W'($past(pin_config_lock)))
    else $error("Lock readback wrong.");

  AST_RD_OUT: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == rps_pkg::OFS_OUT_ROUTE
      |=> rd_data[rps_pkg::PIN1_SEL_LSB +: rps_pkg::SEL_W] == $past(pin1_output_function_sel)
      && rd_data[rps_pkg::PIN0_SEL_LSB +: rps_pkg::SEL_W] == $past(pin0_output_function_sel))
    else $error("Output-route readback wrong.");

  AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> $stable(rd_data) && $stable(spi_slave_select_input)
      && $stable(remappable_pin_zero) && $stable(remappable_pin_one)
      && $stable(pin_config_lock) && $stable(slave_select_input_pin_sel) && $stable(pin_sync))
    else $error("State moved while the clock enable was low.");

endmodule : rps_top
`default_nettype wire

/* verif/rps_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_far_model (
  input  wire logic        core_clk,
  input  wire logic [25:0] pin_set,
  input  wire logic [31:0] func_set,
  output var  logic [25:0] pin_lvl,
  output var  logic [31:0] func_out
);
  // Pads and peripherals lag the bench by a clock, so the design never sees instant changes.
  always_ff @(posedge core_clk)
  begin
    pin_lvl  <= pin_set;
    func_out <= func_set;
  end
endmodule : rps_far_model
`default_nettype wire

/* verif/rps_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_top_tb;
  typedef struct packed {
    logic [15:0] in_w;
    logic [15:0] out_w;
    logic [25:0] pins;
    logic [31:0] funcs;
  } rps_row_t;
  logic                  core_clk = 1'b0;
  logic                  rst_n    = 1'b0;
  logic                  clk_en   = 1'b1;
  rps_pkg::rps_bus_req_t bus_req  = '0;
  logic [15:0]           rd_data;
  logic [25:0]           pin_set  = '0;
  logic [25:0]           pin_lvl;
  logic [31:0]           func_set = '0;
  logic [31:0]           func_out;
  logic                  ss, p0, p1, oe0, oe1, lock;
  int                    errors    = 0;
  int                    tests_run = 0;
  rps_row_t rows [4] = '{'{16'hffe0, 16'hff01, 26'h3fffffe, 32'h80000002},
                         '{16'h0001, 16'h0000, 26'h3fffffd, 32'hffffffff},
                         '{16'h0019, 16'h0302, 26'h2000000, 32'h00000004},
                         '{16'h001e, 16'h1f1f, 26'h0000000, 32'h7fffffff}};
  rps_top rps_top_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
    .rd_data(rd_data), .remappable_pin_in(pin_lvl), .periph_out(func_out),
    .spi_slave_select_input(ss), .remappable_pin_zero(p0), .remappable_pin_one(p1),
    .remappable_pin_zero_oe(oe0), .remappable_pin_one_oe(oe1), .pin_config_lock(lock));
  rps_far_model rps_far_model_inst (.core_clk(core_clk), .pin_set(pin_set),
    .func_set(func_set), .pin_lvl(pin_lvl), .func_out(func_out));
  initial forever #50 core_clk = ~core_clk;
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input string name, input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk) bus_req.rd <= 1'b0;
    #1 chk(name, exp, rd_data);
  endtask : rd
  function automatic logic [4:0] exp_out(input rps_row_t r);
    logic [4:0] s;
    logic [4:0] f0;
    logic [4:0] f1;
    s  = r.in_w[4:0];
    f0 = r.out_w[4:0];
    f1 = r.out_w[12:8];
    // Codes past the last pin leave the input idle high.
    return {(s < 5'd26) ? r.pins[s] : 1'b1, (f0 != 0) & r.funcs[f0],
            (f1 != 0) & r.funcs[f1], f0 != 0, f1 != 0};
  endfunction : exp_out
  task automatic give_verdict;
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    #2ms errors++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("outs", 16'h0020, {10'h0, ss, p0, p1, oe0, oe1, lock});
    rd("in", rps_pkg::OFS_IN_ROUTE, 16'h001f);
    rd("out", rps_pkg::OFS_OUT_ROUTE, 16'h0000);
    foreach (rows[i])
    begin
      wr(rps_pkg::OFS_IN_ROUTE, rows[i].in_w);
      wr(rps_pkg::OFS_OUT_ROUTE, rows[i].out_w);
      rd("in", rps_pkg::OFS_IN_ROUTE, rows[i].in_w & 16'h001f);
      rd("out", rps_pkg::OFS_OUT_ROUTE, rows[i].out_w & 16'h1f1f);
      @(posedge core_clk);
      pin_set  <= rows[i].pins;
      func_set <= rows[i].funcs;
      // Model lag of one cycle plus three cycles through the design.
      repeat (4) @(posedge core_clk);
      #1 chk("pins", {11'h0, exp_out(rows[i])}, {11'h0, ss, p0, p1, oe0, oe1});
    end
    wr(rps_pkg::OFS_LOCK, 16'hffff);
    rd("lock", rps_pkg::OFS_LOCK, 16'h0001);
    wr(rps_pkg::OFS_IN_ROUTE, 16'h0004);
    wr(rps_pkg::OFS_OUT_ROUTE, 16'h0505);
    rd("in", rps_pkg::OFS_IN_ROUTE, 16'h001e);
    rd("out", rps_pkg::OFS_OUT_ROUTE, 16'h1f1f);
    wr(rps_pkg::OFS_LOCK, 16'h0000);
    wr(rps_pkg::OFS_IN_ROUTE, 16'h0004);
    rd("in", rps_pkg::OFS_IN_ROUTE, 16'h0004);
    // A write while the clock enable is low must leave the selector alone.
    @(posedge core_clk) clk_en <= 1'b0;
    wr(rps_pkg::OFS_IN_ROUTE, 16'h0009);
    @(posedge core_clk) clk_en <= 1'b1;
    rd("frozen", rps_pkg::OFS_IN_ROUTE, 16'h0004);
    wr(rps_pkg::OFS_LOCK, 16'h0001);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("reset outs", 16'h0020, {10'h0, ss, p0, p1, oe0, oe1, lock});
    rd("reset in", rps_pkg::OFS_IN_ROUTE, 16'h001f);
    rd("reset out", rps_pkg::OFS_OUT_ROUTE, 16'h0000);
    wr(rps_pkg::OFS_OUT_ROUTE, 16'h0201);
    rd("reset wr", rps_pkg::OFS_OUT_ROUTE, 16'h0201);
    rd("unmapped", 4'hf, 16'h0000);
    give_verdict();
  end
endmodule : rps_top_tb
`default_nettype wire
